// File: hw/abg_baud_gen.sv
// Asynchronous baudrate generator: prescaler, 13-bit reload timer,
// 16x sample clock, bit clock and 7/8/9 receive sampling with vote.
// Assumes a single AHB-Lite master, hclk at 40 MHz, rx_pin asynchronous.
`timescale 1ns/1ps
`default_nettype none

module abg_baud_gen (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Receiver side
    input wire logic rx_pin,
    input wire logic bit_restart,
    // Clocks to the serial channel
    output logic div_clock,
    output logic sample_clock,
    output logic bit_clock,
    output logic sample_point,
    output logic rx_bit,
    output logic rx_bit_valid
);

    typedef struct packed {
        // Bus pipeline
        logic dp_valid;
        logic dp_write;
        logic [abg_pkg::ABG_ADDR_W-1:0] dp_addr;
        // Control registers
        logic run;
        logic fde;
        logic fixed_ratio_select;
        logic [abg_pkg::ABG_RELOAD_W-1:0] reload;
        logic [abg_pkg::ABG_FRAC_W-1:0] fraction;
        logic reload_pend;
        // Prescaler
        logic [1:0] fix_cnt;
        logic [abg_pkg::ABG_FRAC_W-1:0] frac_acc;
        logic div_tick;
        // Timer and phase
        logic [abg_pkg::ABG_RELOAD_W-1:0] count;
        logic [abg_pkg::ABG_PHASE_W-1:0] phase;
        logic sample_clk;
        logic bit_clk;
        logic sample_pt;
        // Receive sampling
        logic [1:0] votes;
        logic rx_bit;
        logic rx_valid;
        // Pin synchroniser
        logic rx_meta;
        logic rx_sync;
        // Bus outputs
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } abg_state_s;

    abg_state_s state_r;
    abg_state_s state_nxt;

    always_comb begin
        logic [abg_pkg::ABG_FRAC_W:0] frac_sum;
        logic [abg_pkg::ABG_PHASE_W-1:0] ph;
        logic [1:0] fix_last;
        logic [abg_pkg::ABG_ADDR_W-1:0] ra;
        logic reload_wr;
        frac_sum = '0;
        ph = '0;
        fix_last = '0;
        ra = '0;
        reload_wr = 1'b0;
        state_nxt = state_r;

        // Pin synchroniser
        state_nxt.rx_meta = rx_pin;
        state_nxt.rx_sync = state_r.rx_meta;

        // Single-cycle pulses default low
        state_nxt.div_tick = 1'b0;
        state_nxt.sample_clk = 1'b0;
        state_nxt.bit_clk = 1'b0;
        state_nxt.sample_pt = 1'b0;
        state_nxt.rx_valid = 1'b0;

        // Data phase of a write
        state_nxt.dp_valid = 1'b0;
        if (state_r.dp_valid && state_r.dp_write) begin
            if (state_r.dp_addr == abg_pkg::ABG_OFS_CTRL) begin
                state_nxt.run = hwdata[abg_pkg::ABG_CTRL_RUN_BIT];
                state_nxt.fde = hwdata[abg_pkg::ABG_CTRL_FDE_BIT];
                state_nxt.fixed_ratio_select = hwdata[abg_pkg::ABG_CTRL_BRS_BIT];
            end else if (state_r.dp_addr == abg_pkg::ABG_OFS_RELOAD) begin
                state_nxt.reload = hwdata[abg_pkg::ABG_RELOAD_W-1:0];
                state_nxt.reload_pend = 1'b1;
                reload_wr = 1'b1;
            end else if (state_r.dp_addr == abg_pkg::ABG_OFS_FRACTION) begin
                state_nxt.fraction = hwdata[abg_pkg::ABG_FRAC_W-1:0];
            end
        end

        // Prescaler and timer
        if (!state_r.run) begin
            state_nxt.fix_cnt = '0;
            state_nxt.frac_acc = '0;
        end else begin
            if (state_r.fde) begin
                // Fractional: carry out of n/512 accumulator, zero means every clock
                frac_sum = {1'b0, state_r.frac_acc} + {1'b0, state_r.fraction};
                state_nxt.frac_acc = frac_sum[abg_pkg::ABG_FRAC_W-1:0];
                state_nxt.div_tick = frac_sum[abg_pkg::ABG_FRAC_W]
                    || (state_r.fraction == '0);
            end else begin
                fix_last = state_r.fixed_ratio_select ? abg_pkg::ABG_FIX_LAST_HI
                                       : abg_pkg::ABG_FIX_LAST_LO;
                if (state_r.fix_cnt >= fix_last) begin
                    state_nxt.fix_cnt = '0;
                    state_nxt.div_tick = 1'b1;
                end else begin
                    state_nxt.fix_cnt = state_r.fix_cnt + 2'h1;
                end
            end

            if (state_r.reload_pend) begin
                // Reload write takes effect once the timer runs
                state_nxt.count = state_r.reload;
                // A write in this cycle keeps the load pending
                state_nxt.reload_pend = reload_wr;
            end else if (state_r.div_tick) begin
                if (state_r.count == '0) begin
                    state_nxt.count = state_r.reload;
                    state_nxt.sample_clk = 1'b1;
                    ph = state_r.phase + 4'h1;
                    state_nxt.phase = ph;
                    state_nxt.bit_clk = (ph == abg_pkg::ABG_PHASE_WRAP);
                    if (ph == abg_pkg::ABG_SAMPLE_A) begin
                        state_nxt.votes[0] = state_r.rx_sync;
                        state_nxt.sample_pt = 1'b1;
                    end else if (ph == abg_pkg::ABG_SAMPLE_B) begin
                        state_nxt.votes[1] = state_r.rx_sync;
                        state_nxt.sample_pt = 1'b1;
                    end else if (ph == abg_pkg::ABG_SAMPLE_C) begin
                        state_nxt.rx_bit = (state_r.votes[0] & state_r.votes[1])
                            | (state_r.votes[0] & state_r.rx_sync)
                            | (state_r.votes[1] & state_r.rx_sync);
                        state_nxt.rx_valid = 1'b1;
                        state_nxt.sample_pt = 1'b1;
                    end
                end else begin
                    state_nxt.count = state_r.count - 13'h0001;
                end
            end
        end

        // Receiver resynchronises the bit period to a start edge
        if (bit_restart) begin
            state_nxt.phase = abg_pkg::ABG_PHASE_WRAP;
        end

        // Address phase
        if (hsel && hready && htrans[1]) begin
            state_nxt.dp_valid = 1'b1;
            state_nxt.dp_write = hwrite;
            state_nxt.dp_addr = haddr[abg_pkg::ABG_ADDR_W-1:0];
        end

        // Read data from the state as it will stand after any pending write
        ra = haddr[abg_pkg::ABG_ADDR_W-1:0];
        state_nxt.hrdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (ra == abg_pkg::ABG_OFS_CTRL) begin
                state_nxt.hrdata[abg_pkg::ABG_CTRL_RUN_BIT] = state_nxt.run;
                state_nxt.hrdata[abg_pkg::ABG_CTRL_FDE_BIT] = state_nxt.fde;
                state_nxt.hrdata[abg_pkg::ABG_CTRL_BRS_BIT] = state_nxt.fixed_ratio_select;
            end else if (ra == abg_pkg::ABG_OFS_RELOAD) begin
                state_nxt.hrdata[abg_pkg::ABG_RELOAD_W-1:0] = state_nxt.count;
            end else if (ra == abg_pkg::ABG_OFS_FRACTION) begin
                state_nxt.hrdata[abg_pkg::ABG_FRAC_W-1:0] = state_nxt.fraction;
            end else if (ra == abg_pkg::ABG_OFS_STATUS) begin
                state_nxt.hrdata[abg_pkg::ABG_STAT_RXBIT_BIT] = state_nxt.rx_bit;
                state_nxt.hrdata[abg_pkg::ABG_STAT_PEND_BIT] = state_nxt.reload_pend;
                state_nxt.hrdata[abg_pkg::ABG_STAT_PHASE_LSB +: abg_pkg::ABG_PHASE_W] =
                    state_nxt.phase;
            end
        end
        state_nxt.hreadyout = 1'b1;
        state_nxt.hresp = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Bus pipeline
            state_r.dp_valid <= 1'b0;
            state_r.dp_write <= 1'b0;
            state_r.dp_addr <= '0;
            // Control registers
            state_r.run <= abg_pkg::ABG_RUN_RST;
            state_r.fde <= abg_pkg::ABG_FDE_RST;
            state_r.fixed_ratio_select <= abg_pkg::ABG_BRS_RST;
            state_r.reload <= abg_pkg::ABG_RELOAD_RST;
            state_r.fraction <= abg_pkg::ABG_FRAC_RST;
            state_r.reload_pend <= 1'b0;
            // Prescaler
            state_r.fix_cnt <= '0;
            state_r.frac_acc <= '0;
            state_r.div_tick <= 1'b0;
            // Timer and phase
            state_r.count <= '0;
            state_r.phase <= '0;
            state_r.sample_clk <= 1'b0;
            state_r.bit_clk <= 1'b0;
            state_r.sample_pt <= 1'b0;
            // Receive sampling
            state_r.votes <= '0;
            state_r.rx_bit <= 1'b0;
            state_r.rx_valid <= 1'b0;
            // Pin synchroniser
            state_r.rx_meta <= 1'b0;
            state_r.rx_sync <= 1'b0;
            // Bus outputs
            state_r.hrdata <= '0;
            state_r.hreadyout <= 1'b1;
            state_r.hresp <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign hrdata = state_r.hrdata;
    assign hreadyout = state_r.hreadyout;
    assign hresp = state_r.hresp;
    assign div_clock = state_r.div_tick;
    assign sample_clock = state_r.sample_clk;
    assign bit_clock = state_r.bit_clk;
    assign sample_point = state_r.sample_pt;
    assign rx_bit = state_r.rx_bit;
    assign rx_bit_valid = state_r.rx_valid;

endmodule // abg_baud_gen

`default_nettype wire

// File: hw/abg_pkg.sv
// Constants for the asynchronous baudrate generator.
// Assumes a 32-bit AHB-Lite register bus, one word per register.
package abg_pkg;

    // Register byte offsets
    localparam logic [7:0] ABG_OFS_CTRL = 8'h00;
    localparam logic [7:0] ABG_OFS_RELOAD = 8'h04;
    localparam logic [7:0] ABG_OFS_FRACTION = 8'h08;
    localparam logic [7:0] ABG_OFS_STATUS = 8'h0C;
    localparam int ABG_ADDR_W = 8;

    // Control register fields
    localparam int ABG_CTRL_RUN_BIT = 0;
    localparam int ABG_CTRL_FDE_BIT = 1;
    localparam int ABG_CTRL_BRS_BIT = 2;

    // Status register fields
    localparam int ABG_STAT_RXBIT_BIT = 0;
    localparam int ABG_STAT_PEND_BIT = 1;
    localparam int ABG_STAT_PHASE_LSB = 4;

    // Widths
    localparam int ABG_RELOAD_W = 13;
    localparam int ABG_FRAC_W = 9;
    localparam int ABG_PHASE_W = 4;

    // Reset values
    localparam logic [ABG_RELOAD_W-1:0] ABG_RELOAD_RST = 13'h0000;
    localparam logic [ABG_FRAC_W-1:0] ABG_FRAC_RST = 9'h000;
    localparam logic ABG_RUN_RST = 1'b0;
    localparam logic ABG_FDE_RST = 1'b0;
    localparam logic ABG_BRS_RST = 1'b0;

    // Fixed prescaler terminal counts (divide by 2 and by 3)
    localparam logic [1:0] ABG_FIX_LAST_LO = 2'h1;
    localparam logic [1:0] ABG_FIX_LAST_HI = 2'h2;

    // Sample ticks per bit period and the three sampling ticks
    localparam int ABG_SAMPLES_PER_BIT = 16;
    localparam logic [ABG_PHASE_W-1:0] ABG_SAMPLE_A = 4'h7;
    localparam logic [ABG_PHASE_W-1:0] ABG_SAMPLE_B = 4'h8;
    localparam logic [ABG_PHASE_W-1:0] ABG_SAMPLE_C = 4'h9;
    localparam logic [ABG_PHASE_W-1:0] ABG_PHASE_WRAP = 4'h0;

endpackage

// File: bench/abg_baud_gen_checker.sv
// Port assertions for the baudrate generator.
// Bound to every abg_baud_gen instance; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module abg_baud_gen_checker (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Serial clocks
    input wire logic div_clock,
    input wire logic sample_clock,
    input wire logic bit_clock,
    input wire logic sample_point,
    input wire logic rx_bit,
    input wire logic rx_bit_valid
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_addr;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence rd_reload;
        rd_addr ##0 (haddr[7:0] == abg_pkg::ABG_OFS_RELOAD);
    endsequence
    reload_upper_a: assert property (rd_reload |=> hrdata[31:13] == 19'h0)
        else $error("reload read upper bits not zero");
    idle_rdata_a: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
        else $error("read data outside read data phase");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    sample_div_a: assert property (sample_clock |-> $past(div_clock))
        else $error("sample pulse without timer input tick");
    bit_sample_a: assert property (bit_clock |-> sample_clock)
        else $error("bit pulse off a sample pulse");
    point_sample_a: assert property (sample_point |-> sample_clock && !bit_clock)
        else $error("sample point misplaced");
    valid_point_a: assert property (rx_bit_valid |-> sample_point)
        else $error("rx valid off a sample point");
    rx_hold_a: assert property (!rx_bit_valid |-> $stable(rx_bit))
        else $error("rx bit changed without valid");
endmodule // abg_baud_gen_checker
bind abg_baud_gen abg_baud_gen_checker i_abg_baud_gen_checker (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .div_clock(div_clock),
    .sample_clock(sample_clock), .bit_clock(bit_clock), .sample_point(sample_point),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid));
`default_nettype wire

// File: bench/abg_baud_gen_tb.sv
// Self-checking bench for the baudrate generator.
// Drives the bus and rx pin itself; measures the output pulses.
`timescale 1ns/1ps
`default_nettype none
module abg_baud_gen_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic rx_pin = 1'b1;
    logic bit_restart = 1'b0;
    logic [31:0] hrdata, rd, hold;
    logic hreadyout, hresp, div_clock, sample_clock, bit_clock, sample_point, rx_bit, rx_bit_valid;
    logic [31:0] seed = 32'h92D1E2BB;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    int per, ns, mask, nd;
    int cf_fde[5] = '{0, 0, 1, 1, 1};
    int cf_brs[5] = '{0, 1, 1, 0, 1};
    int cf_r[5] = '{0, 2, 1, 3, 1};
    int cf_n[5] = '{0, 0, 0, 256, 128};
    abg_baud_gen i_abg_baud_gen (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_pin(rx_pin),
        .bit_restart(bit_restart), .div_clock(div_clock), .sample_clock(sample_clock),
        .bit_clock(bit_clock), .sample_point(sample_point), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid));
    always #12.5 hclk = ~hclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic meas();
        do @(posedge hclk); while (bit_clock !== 1'b1);
        per = 0;
        ns = 0;
        mask = 0;
        nd = 0;
        do begin
            @(posedge hclk);
            per++;
            nd += int'(div_clock === 1'b1);
            ns += int'(sample_clock === 1'b1);
            if (sample_point === 1'b1) mask |= 1 << ns;
            if (rx_bit_valid === 1'b1) mask |= 1 << (ns + 16);
        end while (bit_clock !== 1'b1);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int a = 0; a < 20; a += 4) begin
            bus(1'b0, 8'(a), 32'h0);
            chk(rd, 32'h0);
        end
        bus(1'b1, abg_pkg::ABG_OFS_CTRL, 32'hFFFFFFF6);
        bus(1'b0, abg_pkg::ABG_OFS_CTRL, 32'h0);
        chk(rd, 32'h6);
        bus(1'b1, abg_pkg::ABG_OFS_FRACTION, 32'hFFFFFFFF);
        bus(1'b0, abg_pkg::ABG_OFS_FRACTION, 32'h0);
        chk(rd, 32'h1FF);
        bus(1'b1, 8'h10, 32'hFFFFFFFF);
        bus(1'b1, abg_pkg::ABG_OFS_RELOAD, 32'hFFFFFFFF);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, abg_pkg::ABG_OFS_RELOAD, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            rx_pin <= seed[0];
            bus(1'b1, abg_pkg::ABG_OFS_CTRL, 32'h0);
            bus(1'b1, abg_pkg::ABG_OFS_RELOAD, {seed[31:13], 13'(cf_r[i])});
            bus(1'b1, abg_pkg::ABG_OFS_FRACTION, 32'(cf_n[i]));
            bus(1'b1, abg_pkg::ABG_OFS_CTRL, 32'(1 + 2 * cf_fde[i] + 4 * cf_brs[i]));
            meas();
            meas();
            chk(32'(per), 32'(16 * (cf_r[i] + 1) * (cf_fde[i] ? (cf_n[i] ? 512 / cf_n[i] : 1)
                : 2 + cf_brs[i])));
            chk(32'(ns), 32'h10);
            chk(32'(mask), 32'h02000380);
            chk(32'(nd), 32'(16 * (cf_r[i] + 1)));
            bus(1'b0, abg_pkg::ABG_OFS_RELOAD, 32'h0);
            chk(32'(rd <= 32'(cf_r[i])), 32'h1);
            bus(1'b0, abg_pkg::ABG_OFS_STATUS, 32'h0);
            chk({31'h0, rd[0]}, {31'h0, seed[0]});
            chk({31'h0, rx_bit}, {31'h0, seed[0]});
        end
        do @(posedge hclk); while (sample_point !== 1'b1);
        bus(1'b1, abg_pkg::ABG_OFS_CTRL, 32'h0);
        repeat (2) @(posedge hclk);
        bus(1'b0, abg_pkg::ABG_OFS_RELOAD, 32'h0);
        hold = rd;
        ns = 0;
        repeat (64) begin
            @(posedge hclk);
            ns += int'(sample_clock === 1'b1);
        end
        chk(32'(ns), 32'h0);
        bus(1'b0, abg_pkg::ABG_OFS_RELOAD, 32'h0);
        chk(rd, hold);
        bus(1'b0, abg_pkg::ABG_OFS_STATUS, 32'h0);
        chk({28'h0, rd[7:4]}, {28'h0, abg_pkg::ABG_SAMPLE_A});
        bit_restart <= 1'b1;
        @(posedge hclk);
        bit_restart <= 1'b0;
        bus(1'b0, abg_pkg::ABG_OFS_STATUS, 32'h0);
        chk({28'h0, rd[7:4]}, {28'h0, abg_pkg::ABG_PHASE_WRAP});
        test_done();
    end
endmodule // abg_baud_gen_tb
`default_nettype wire
